// ===== rtl/monitor_sense_if.sv
// signals between the control logic and the comparator sense logic
`timescale 1ns/1ps
`default_nettype none

interface monitor_sense_if;
  logic raw_above;
  logic power_on;
  logic above_sync;
  logic settled;

  modport sense (input raw_above, input power_on,
                 output above_sync, output settled);
  modport ctrl (output raw_above, output power_on,
                input above_sync, input settled);
endinterface : monitor_sense_if

`default_nettype wire

// ===== rtl/supply_monitor_defines.svh
// offsets, field positions, reset values and timing counts of the monitor
`ifndef SUPPLY_MONITOR_DEFINES_SVH
`define SUPPLY_MONITOR_DEFINES_SVH

// ----------------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------------
`define CTRL_ADDR 8'hff
`define CAUSE_ADDR 8'hef

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ON_BIT 7
`define STAT_BIT 6
`define HIGH_BIT 5
`define FLAG_BIT 1

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define ON_RST 1'b1
`define HIGH_RST 1'b0
`define SELECT_RST 1'b1
`define FLAG_RST 1'b1

// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define SETTLE_NS 5000
`define SETTLE_CYC ((`SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ===== rtl/supply_monitor_pkg.sv
// types shared by the supply monitor modules
package supply_monitor_pkg;

  typedef logic [7:0] byte_t;

  typedef enum logic [0:0] {
    st_run = 1'b0,
    st_hold = 1'b1
  } hold_state_e;

endpackage : supply_monitor_pkg

// ===== rtl/supply_monitor_reset.sv
// supply monitor control register, power-fail reset and flash guard
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.svh"

module supply_monitor_reset (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic other_reset,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic sfr_rd_en,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic cmp_above,
  output logic monitor_power_on,
  output logic threshold_high_select,
  input wire logic flash_write_try,
  output logic flash_error_reset,
  output logic core_hold_reset,
  output logic rst_pin_out,
  output logic rst_pin_oe_n
);

  // every check in this module runs on the one clock, off in reset
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic is_ctrl(input logic [7:0] addr);
    is_ctrl = (addr == `CTRL_ADDR);
  endfunction : is_ctrl

  function automatic logic is_cause(input logic [7:0] addr);
    is_cause = (addr == `CAUSE_ADDR);
  endfunction : is_cause

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  monitor_sense_if sense_if ();

  logic supply_monitor_on_q;
  logic threshold_high_select_q;
  logic monitor_select_q;
  logic power_on_flag_q;
  supply_monitor_pkg::hold_state_e state_q;
  supply_monitor_pkg::hold_state_e state_d;
  supply_monitor_pkg::byte_t rdata_q;
  logic flash_err_q;
  logic supply_reset_req;
  logic hold_exit;
  logic supply_above_threshold;
  logic wr_ctrl;
  logic wr_cause;

  assign wr_ctrl = sfr_wr_en && is_ctrl(sfr_addr);
  assign wr_cause = sfr_wr_en && is_cause(sfr_addr);

  supply_sense u_sense (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .sense(sense_if.sense)
  );

  assign sense_if.raw_above = cmp_above;
  assign sense_if.power_on = supply_monitor_on_q;

  // status reads low until the comparator has settled
  assign supply_above_threshold = sense_if.above_sync & sense_if.settled;

  // ----------------------------------------------------------------------
  // enable bit: only power-on resets it, other resets leave it alone
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      supply_monitor_on_q <= `ON_RST;
    end else if (wr_ctrl) begin
      supply_monitor_on_q <= sfr_wdata[`ON_BIT];
    end
  end

  // threshold select returns to the low default on any reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      threshold_high_select_q <= `HIGH_RST;
    end else if (other_reset) begin
      threshold_high_select_q <= `HIGH_RST;
    end else if (wr_ctrl) begin
      threshold_high_select_q <= sfr_wdata[`HIGH_BIT];
    end
  end

  // reset-source selection written through the flag bit position
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      monitor_select_q <= `SELECT_RST;
    end else if (wr_cause) begin
      monitor_select_q <= sfr_wdata[`FLAG_BIT];
    end
  end

  // power-on flag: set wins over the clear by another reset
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      power_on_flag_q <= `FLAG_RST;
    end else if (hold_exit) begin
      power_on_flag_q <= 1'b1;
    end else if (other_reset) begin
      power_on_flag_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // power-fail hold; chatter during settling is not masked
  // ----------------------------------------------------------------------
  assign supply_reset_req = supply_monitor_on_q && monitor_select_q &&
                            !sense_if.above_sync;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      supply_monitor_pkg::st_run: begin
        if (supply_reset_req) begin
          state_d = supply_monitor_pkg::st_hold;
        end
      end
      supply_monitor_pkg::st_hold: begin
        if (!supply_reset_req) begin
          state_d = supply_monitor_pkg::st_run;
        end
      end
    endcase
  end

  // hold from power-on until the synchronised comparator reports good
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= supply_monitor_pkg::st_hold;
    end else begin
      state_q <= state_d;
    end
  end

  assign hold_exit = (state_q == supply_monitor_pkg::st_hold) &&
                     (state_d == supply_monitor_pkg::st_run);

  // open-drain reset pin, only ever pulled low
  assign core_hold_reset = (state_q == supply_monitor_pkg::st_hold);
  assign rst_pin_out = 1'b0;
  assign rst_pin_oe_n = !core_hold_reset;

  // ----------------------------------------------------------------------
  // flash guard
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      flash_err_q <= 1'b0;
    end else begin
      flash_err_q <= flash_write_try && !supply_monitor_on_q;
    end
  end

  assign flash_error_reset = flash_err_q;

  // ----------------------------------------------------------------------
  // register read port, one cycle latency
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (sfr_rd_en) begin
      rdata_q <= 8'h00;
      if (is_ctrl(sfr_addr)) begin
        rdata_q[`ON_BIT] <= supply_monitor_on_q;
        rdata_q[`STAT_BIT] <= supply_above_threshold;
        rdata_q[`HIGH_BIT] <= threshold_high_select_q;
      end else if (is_cause(sfr_addr)) begin
        rdata_q[`FLAG_BIT] <= power_on_flag_q;
      end
    end
  end

  assign sfr_rdata = rdata_q;
  assign monitor_power_on = supply_monitor_on_q;
  assign threshold_high_select = threshold_high_select_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_hold_on_low: assert property (
    supply_reset_req |=> core_hold_reset)
    else $error("low supply did not hold the core");

  a_pin_with_hold: assert property (
    core_hold_reset |-> !rst_pin_oe_n && !rst_pin_out)
    else $error("reset pin not driven during hold");

  a_release_on_good: assert property (
    core_hold_reset && sense_if.above_sync |=> !core_hold_reset)
    else $error("core not released after recovery");

  a_no_delay: assert property (
    $fell(core_hold_reset) |-> $past(sense_if.above_sync))
    else $error("release not tied to recovery");

  a_keep_enable: assert property (
    other_reset && !wr_ctrl |=> $stable(supply_monitor_on_q))
    else $error("other reset changed the enable");

  a_flash_error: assert property (
    flash_write_try && !supply_monitor_on_q |=> flash_error_reset)
    else $error("missing flash-error reset");

  a_flash_quiet: assert property (
    flash_error_reset |-> $past(flash_write_try && !supply_monitor_on_q))
    else $error("spurious flash-error reset");

  a_select_write: assert property (
    wr_cause |=> monitor_select_q == $past(sfr_wdata[`FLAG_BIT]))
    else $error("select not taken from flag bit");

  a_threshold_pin: assert property (
    wr_ctrl && !other_reset |=>
    threshold_high_select == $past(sfr_wdata[`HIGH_BIT]))
    else $error("threshold select not applied");

  a_status_read: assert property (
    sfr_rd_en && is_ctrl(sfr_addr) |=>
    sfr_rdata[`STAT_BIT] == $past(supply_above_threshold))
    else $error("status bit wrong");

  a_reserved_zero: assert property (
    $past(sfr_rd_en && is_ctrl(sfr_addr)) |-> sfr_rdata[4:0] == 5'h00)
    else $error("reserved bits not zero");

  a_flag_clear: assert property (
    other_reset && !hold_exit |=> !power_on_flag_q)
    else $error("flag not cleared by other reset");

  a_flag_set: assert property (
    hold_exit |=> power_on_flag_q)
    else $error("flag not set on hold exit");

  c_brownout: cover property (
    !core_hold_reset ##1 core_hold_reset ##[1:20] !core_hold_reset);

  c_flash_err: cover property (
    flash_error_reset);

  c_reenable: cover property (
    !supply_monitor_on_q ##1 supply_monitor_on_q ##[1:300] wr_cause);

  c_other_reset: cover property (
    other_reset && !supply_monitor_on_q);

endmodule : supply_monitor_reset

`default_nettype wire

// ===== rtl/supply_sense.sv
// comparator synchroniser and turn-on settling counter
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.svh"

module supply_sense (
  input wire logic ref_clk,
  input wire logic nrst,
  monitor_sense_if.sense sense
);

  localparam logic [7:0] SETTLE_LAST = 8'(`SETTLE_CYC - 1);

  logic meta_q;
  logic above_q;
  logic [7:0] cnt_q;
  logic settled_q;

  // ----------------------------------------------------------------------
  // two-stage synchroniser on the comparator output
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      above_q <= 1'b0;
    end else begin
      meta_q <= sense.raw_above;
      above_q <= meta_q;
    end
  end

  // settling count restarts whenever the monitor is switched off
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_q <= 8'h00;
      settled_q <= 1'b0;
    end else if (!sense.power_on) begin
      cnt_q <= 8'h00;
      settled_q <= 1'b0;
    end else begin
      if (cnt_q != SETTLE_LAST) begin
        cnt_q <= cnt_q + 8'h01;
      end
      settled_q <= (cnt_q == SETTLE_LAST);
    end
  end

  assign sense.above_sync = above_q;
  assign sense.settled = settled_q;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_settle_time: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    $rose(sense.power_on) |=> !sense.settled ##[195:205] sense.settled)
    else $error("monitor did not settle in time");

  a_off_unsettled: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !sense.power_on |=> !sense.settled)
    else $error("settled while monitor off");

endmodule : supply_sense

`default_nettype wire

// ===== tb/supply_partner.sv
// comparator and reset pin model on the far side of the monitor
`timescale 1ns/1ps
`default_nettype none

module supply_partner (
  input wire logic ref_clk,
  input wire logic [1:0] supply_level,
  input wire logic monitor_power_on,
  input wire logic threshold_high_select,
  input wire logic rst_pin_out,
  input wire logic rst_pin_oe_n,
  output logic cmp_above,
  output logic rst_pin_level
);
  logic junk_q = 1'b0;

  // a comparator that is off gives no valid answer
  always @(posedge ref_clk) begin
    junk_q <= !junk_q;
  end

  // level 0 under both thresholds, 1 between them, 2 over both
  always_comb begin
    if (monitor_power_on) begin
      cmp_above = supply_level > {1'b0, threshold_high_select};
    end else begin
      cmp_above = junk_q;
    end
  end

  // pin has a pull-up and is pulled low only while enabled
  assign rst_pin_level = rst_pin_oe_n ? 1'b1 : rst_pin_out;
endmodule : supply_partner

`default_nettype wire

// ===== tb/test_supply_monitor_reset.sv
// self-checking bench for the supply monitor reset block
`timescale 1ns/1ps
`default_nettype none
`include "supply_monitor_defines.svh"

module test_supply_monitor_reset;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic other_reset = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr_en = 1'b0;
  logic sfr_rd_en = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic flash_write_try = 1'b0;
  logic [1:0] supply_level = 2'h2;
  logic [7:0] sfr_rdata;
  logic cmp_above;
  logic monitor_power_on;
  logic threshold_high_select;
  logic flash_error_reset;
  logic core_hold_reset;
  logic rst_pin_out;
  logic rst_pin_oe_n;
  logic rst_pin_level;
  logic [7:0] d;
  int fail_count = 0;
  int cmp_count = 0;
  int seed = 32'hcd0f;
  int m_on = 1;
  int m_high = 0;

  supply_monitor_reset DUT (.ref_clk(ref_clk), .nrst(nrst),
    .other_reset(other_reset), .sfr_addr(sfr_addr), .sfr_wr_en(sfr_wr_en),
    .sfr_rd_en(sfr_rd_en), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_above(cmp_above), .monitor_power_on(monitor_power_on),
    .threshold_high_select(threshold_high_select),
    .flash_write_try(flash_write_try), .flash_error_reset(flash_error_reset),
    .core_hold_reset(core_hold_reset), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n));

  supply_partner u_partner (.ref_clk(ref_clk), .supply_level(supply_level),
    .monitor_power_on(monitor_power_on),
    .threshold_high_select(threshold_high_select), .rst_pin_out(rst_pin_out),
    .rst_pin_oe_n(rst_pin_oe_n), .cmp_above(cmp_above),
    .rst_pin_level(rst_pin_level));

  // 40 MHz clock
  always #12.5 ref_clk = !ref_clk;

  // ---------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------
  task automatic stop_test;
    if (fail_count == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string name, input logic [7:0] seen,
                       input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tick;
    @(posedge ref_clk);
    #2;
  endtask : tick

  // control byte the model expects, read only once settled
  function automatic logic [7:0] exp_ctrl();
    logic st;
    st = (m_on != 0) && (int'(supply_level) > m_high);
    return {m_on[0], st, m_high[0], 5'h00};
  endfunction : exp_ctrl

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr_en = 1'b1;
    tick();
    sfr_wr_en = 1'b0;
    if (a == `CTRL_ADDR) begin
      m_on = v[7];
      m_high = v[5];
    end
    tick();
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp,
                    input string name);
    sfr_addr = a;
    sfr_rd_en = 1'b1;
    tick();
    sfr_rd_en = 1'b0;
    check(name, sfr_rdata, exp);
    tick();
  endtask : rd

  // counts edges until the hold reaches v, bounded
  task automatic wait_hold(input logic v, input int lat, input string name);
    int n;
    n = 0;
    while (core_hold_reset !== v && n < 20) begin
      tick();
      n++;
    end
    check(name, n[7:0], lat[7:0]);
    check("pin", {7'h00, rst_pin_level}, {7'h00, !v});
    if (n == 20) begin
      fail_count++;
      stop_test();
    end
  endtask : wait_hold

  // ---------------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------------
  initial begin
    repeat (10) @(posedge ref_clk);
    #2;
    check("hold_in_rst", {7'h00, core_hold_reset}, 8'h01);
    nrst = 1'b1;
    wait_hold(1'b0, 3, "por_release");
    check("por_on", {7'h00, monitor_power_on}, 8'h01);
    repeat (`SETTLE_CYC + 10) tick();
    rd(`CTRL_ADDR, exp_ctrl(), "ctrl_por");
    rd(`CAUSE_ADDR, 8'h02, "flag_por");
    wr(8'h00, 8'hff);
    rd(8'h00, 8'h00, "unmapped");
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[7] = 1'b1; // monitor stays on
      wr(`CTRL_ADDR, d);
      check("thr", {7'h00, threshold_high_select}, {7'h00, d[5]});
      rd(`CTRL_ADDR, exp_ctrl(), "ctrl_rw");
    end
    for (int h = 0; h < 2; h++) begin
      wr(`CTRL_ADDR, {2'h3, h[0], 5'h1f});
      supply_level = 2'(h);
      wait_hold(1'b1, 3, "hold_rise");
      rd(`CTRL_ADDR, exp_ctrl(), "stat_low");
      supply_level = 2'h2;
      wait_hold(1'b0, 3, "hold_fall");
    end
    other_reset = 1'b1;
    tick();
    other_reset = 1'b0;
    m_high = 0;
    tick();
    check("on_kept", {7'h00, monitor_power_on}, 8'h01);
    rd(`CAUSE_ADDR, 8'h00, "flag_clr");
    wr(`CTRL_ADDR, 8'h00);
    other_reset = 1'b1;
    tick();
    other_reset = 1'b0;
    tick();
    check("off_kept", {7'h00, monitor_power_on}, 8'h00);
    supply_level = 2'h0;
    repeat (6) tick();
    check("off_no_hold", {7'h00, core_hold_reset}, 8'h00);
    flash_write_try = 1'b1;
    tick();
    flash_write_try = 1'b0;
    check("ferr", {7'h00, flash_error_reset}, 8'h01);
    tick();
    check("ferr_end", {7'h00, flash_error_reset}, 8'h00);
    wr(`CAUSE_ADDR, 8'h00);
    supply_level = 2'h2;
    wr(`CTRL_ADDR, 8'ha0); // enable first, high level
    flash_write_try = 1'b1;
    tick();
    flash_write_try = 1'b0;
    check("ferr_on", {7'h00, flash_error_reset}, 8'h00);
    repeat (`SETTLE_CYC) tick(); // settling wait
    supply_level = 2'h1;
    repeat (6) tick();
    check("desel", {7'h00, core_hold_reset}, 8'h00);
    wr(`CAUSE_ADDR, 8'h02); // flag bit kept set
    check("sel_hold", {7'h00, core_hold_reset}, 8'h01);
    supply_level = 2'h2;
    wait_hold(1'b0, 3, "sel_fall");
    rd(`CTRL_ADDR, exp_ctrl(), "ctrl_end");
    // flash software: select straight after enabling, no settling wait
    wr(`CAUSE_ADDR, 8'h00);
    wr(`CTRL_ADDR, 8'h20);
    wr(`CTRL_ADDR, 8'ha0);
    wr(`CAUSE_ADDR, 8'h02);
    check("early_sel", {7'h00, core_hold_reset}, 8'h00);
    check("early_on", {7'h00, monitor_power_on}, 8'h01);
    supply_level = 2'h1;
    wait_hold(1'b1, 3, "early_hold");
    supply_level = 2'h2;
    wait_hold(1'b0, 3, "early_fall");
    stop_test();
  end
endmodule : test_supply_monitor_reset

`default_nettype wire
